// ### src/sfsw_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Dual output: lane one odd bits, lane zero even bits, pairs MSB first.
// - Dual address input: odd bits lane one, even lane zero, 23/22 first.
// - Opcode 06 alone in a frame sets the write-enable latch.
// - Opcode 04 alone in a frame clears the write-enable latch.
// - Latch clears at reset, latch clear, register write and array operation end.
// - Opcode 50 keeps the latch; next status write goes to the volatile copy.
// - Opcode 05 shifts out the status byte, accepted even while busy.
// - Status: bit0 busy, bit1 latch, bits2-6 block protect, bit7 lock bit.
// - Busy reads 1 during program, erase or register write, else 0.
// - With the latch clear, status write, program and erase are refused.
// - Block protect bits writable only outside hardware-protected mode.
// - Chip erase runs only when block protect selects no protection.
// - Lock bit 1 with lock pin low locks status; otherwise latch suffices.
// - Opcode 15 shifts out the configuration byte, accepted even while busy.
// - Configuration bit 7 is the dummy-count bit; other bits reserved zero.
// - Dual read BB uses 4 dummy clocks, or 8 with dummy-count bit set.
// - Status write 01 takes one byte; select must rise right after it.
// - Valid non-volatile status write starts a timed cycle, busy meanwhile, latch cleared after.
// - Hardware-protected mode makes the device ignore status writes.
// - Config write 11: one byte, exact framing, timed cycle, latch cleared after.
// - Inputs sampled on rising serial clock, outputs driven on falling, modes 0/3.
// - Unknown opcode: outputs released, clocks ignored until select falls again.
module sfsw_top
    import sfsw_pkg::*;
#(
    parameter int WRITE_TIME_NS = 1000000
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic dual_lane_zero_in,
    input wire logic dual_lane_one_in,
    input wire logic lock_pin_n,
    output logic dual_lane_zero_out,
    output logic dual_lane_zero_oe,
    output logic dual_lane_one_out,
    output logic dual_lane_one_oe,
    input wire logic array_busy,
    input wire logic [7:0] array_rdata,
    output logic array_req,
    output logic [7:0] array_op,
    output logic [23:0] array_addr
);
    localparam int WRITE_CYCLES = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    sfsw_store_if sif ();

    sfsw_reg_store #(
        .WRITE_CYCLES(WRITE_CYCLES)
    ) u_store (
        .ref_clk(ref_clk),
        .reset(reset),
        .ce(ce),
        .sif(sif)
    );

    // Opcodes that hand an operation to the array
    function automatic logic is_array_op(input logic [7:0] op);
        return op == OP_PAGE_PROG || op == OP_PAGE_WIPE || op == OP_4K_WIPE ||
            op == OP_HALF_WIPE || op == OP_BLK_WIPE || is_chip_op(op);
    endfunction : is_array_op

    function automatic logic is_chip_op(input logic [7:0] op);
        return op == OP_CHIP_WIPE_A || op == OP_CHIP_WIPE_B;
    endfunction : is_chip_op

    // Byte left after emitting its top bit or bit pair
    function automatic logic [7:0] shift_out(input logic [7:0] b, input logic dual);
        return dual ? {b[5:0], 2'b00} : {b[6:0], 1'b0};
    endfunction : shift_out

    logic [SY_W-1:0] sy1_r, sy2_r;
    logic sclk_d_r, cs_d_r;
    sfsw_state_t state_r, state_nxt;
    logic [7:0] opc_r, opc_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [7:0] osh_r, osh_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic [2:0] ocnt_r, ocnt_nxt;
    logic [23:0] addr_r, addr_nxt;
    logic bad_r, bad_nxt;
    logic dual_r, dual_nxt;
    logic l1_r, l1_nxt;
    logic l0_r, l0_nxt;
    logic wel_r, wel_nxt;
    logic vol_r, vol_nxt;
    logic req_r, req_nxt;
    logic abusy_d_r;
    logic sclk_rise, sclk_fall, cs_rise, cs_fall;
    logic d0, d1, busy, hw_lock, exec, stat_ok, cfg_ok;
    logic [7:0] status_byte, cfg_byte, cmd_byte, out_byte;
    logic [2:0] out_last;
    logic [4:0] dummy_len;

    // Two flops per pin; only the second stage is read
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sy1_r <= SY_RESET;
            sy2_r <= SY_RESET;
            sclk_d_r <= 1'b0;
            cs_d_r <= 1'b1;
            abusy_d_r <= 1'b0;
        end else if (ce) begin
            sy1_r <= {lock_pin_n, dual_lane_one_in, dual_lane_zero_in, cs_n, sclk};
            sy2_r <= sy1_r;
            sclk_d_r <= sy2_r[SY_SCLK];
            cs_d_r <= sy2_r[SY_CS];
            abusy_d_r <= array_busy;
        end
    end

    // Edges of the sampled serial clock and select
    assign sclk_rise = ce && sy2_r[SY_SCLK] && !sclk_d_r;
    assign sclk_fall = ce && !sy2_r[SY_SCLK] && sclk_d_r;
    assign cs_rise = ce && sy2_r[SY_CS] && !cs_d_r;
    assign cs_fall = ce && !sy2_r[SY_CS] && cs_d_r;
    assign d0 = sy2_r[SY_L0];
    assign d1 = sy2_r[SY_L1];
    assign cmd_byte = {sh_r[6:0], d0};

    // Register views and write permission
    assign busy = sif.busy || array_busy;
    assign status_byte = {sif.lock, sif.bp, wel_r, busy};
    assign cfg_byte = {sif.dum, CFG_RSVD};
    assign hw_lock = sif.lock && !sy2_r[SY_LOCK];
    assign stat_ok = wel_r && !busy && !hw_lock;
    assign cfg_ok = wel_r && !busy;
    assign exec = cs_rise && state_r == S_HOLD && !bad_r;
    assign dummy_len = sif.dum ? DUMMY_LONG : DUMMY_SHORT;
    assign out_last = dual_r ? OUT_LAST_DUAL : OUT_LAST_SINGLE;
    assign out_byte = (opc_r == OP_STAT_RD) ? status_byte :
        (opc_r == OP_CFG_RD) ? cfg_byte : array_rdata;

    // Register writes toward the store; volatile only when armed
    assign sif.wr_nv = exec && ((opc_r == OP_STAT_WR && !vol_r && stat_ok) ||
        (opc_r == OP_CFG_WR && cfg_ok));
    assign sif.wr_vol = exec && opc_r == OP_STAT_WR && vol_r && stat_ok;
    assign sif.wr_cfg = (opc_r == OP_CFG_WR);
    assign sif.wr_data = sh_r;

    // Serial sequencer: select edges win over clock edges
    always_comb begin
        state_nxt = state_r;
        opc_nxt = opc_r;
        sh_nxt = sh_r;
        osh_nxt = osh_r;
        cnt_nxt = cnt_r;
        ocnt_nxt = ocnt_r;
        addr_nxt = addr_r;
        bad_nxt = bad_r;
        dual_nxt = dual_r;
        l1_nxt = l1_r;
        l0_nxt = l0_r;
        if (cs_fall) begin
            state_nxt = S_CMD;
            cnt_nxt = '0;
            bad_nxt = 1'b0;
            dual_nxt = 1'b0;
        end else if (cs_rise) begin
            state_nxt = S_IDLE;
        end else if (sclk_rise) begin
            case (state_r)
                S_CMD: begin
                    sh_nxt = cmd_byte;
                    cnt_nxt = cnt_r + 5'h01;
                    if (cnt_r == BYTE_CLK - 5'h01) begin
                        opc_nxt = cmd_byte;
                        cnt_nxt = '0;
                        ocnt_nxt = '0;
                        if (cmd_byte == OP_STAT_RD || cmd_byte == OP_CFG_RD) begin
                            state_nxt = S_DOUT;
                        end else if (cmd_byte == OP_STAT_WR || cmd_byte == OP_CFG_WR) begin
                            state_nxt = S_DIN;
                        end else if (cmd_byte == OP_LATCH_SET || cmd_byte == OP_LATCH_CLR ||
                            cmd_byte == OP_VOL_EN || is_chip_op(cmd_byte)) begin
                            state_nxt = S_HOLD;
                        end else if (cmd_byte == OP_DUAL_RD) begin
                            // Array reads are turned away during a busy cycle
                            state_nxt = busy ? S_IGNORE : S_ADDR;
                            dual_nxt = 1'b1;
                        end else if (is_array_op(cmd_byte)) begin
                            state_nxt = S_ADDR;
                        end else begin
                            state_nxt = S_IGNORE;
                        end
                    end
                end
                S_ADDR: begin
                    cnt_nxt = cnt_r + 5'h01;
                    if (dual_r) begin
                        addr_nxt = {addr_r[21:0], d1, d0};
                        if (cnt_r == ADDR_CLK_DUAL - 5'h01) begin
                            state_nxt = S_DUMMY;
                            cnt_nxt = '0;
                        end
                    end else begin
                        addr_nxt = {addr_r[22:0], d0};
                        if (cnt_r == ADDR_CLK_SINGLE - 5'h01) begin
                            state_nxt = S_HOLD;
                            cnt_nxt = '0;
                        end
                    end
                end
                S_DUMMY: begin
                    cnt_nxt = cnt_r + 5'h01;
                    if (cnt_r == dummy_len - 5'h01) begin
                        state_nxt = S_DOUT;
                    end
                end
                S_DIN: begin
                    sh_nxt = cmd_byte;
                    cnt_nxt = cnt_r + 5'h01;
                    if (cnt_r == BYTE_CLK - 5'h01) begin
                        state_nxt = S_HOLD;
                        cnt_nxt = '0;
                    end
                end
                S_HOLD: begin
                    // Program data may follow in whole bytes; any other clock spoils it
                    if (opc_r == OP_PAGE_PROG) begin
                        cnt_nxt = (cnt_r == BYTE_CLK - 5'h01) ? 5'h00 : cnt_r + 5'h01;
                        bad_nxt = (cnt_nxt != 5'h00);
                    end else begin
                        bad_nxt = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end else if (sclk_fall && state_r == S_DOUT) begin
            // Fetch a fresh byte at each boundary, then shift MSB first
            if (ocnt_r == '0) begin
                l1_nxt = out_byte[7];
                l0_nxt = out_byte[6];
                osh_nxt = shift_out(out_byte, dual_r);
                if (opc_r == OP_DUAL_RD) begin
                    addr_nxt = addr_r + 24'h000001;
                end
            end else begin
                l1_nxt = osh_r[7];
                l0_nxt = osh_r[6];
                osh_nxt = shift_out(osh_r, dual_r);
            end
            ocnt_nxt = (ocnt_r == out_last) ? 3'h0 : ocnt_r + 3'h1;
        end
    end

    // Latch, volatile arm and array request; a set wins over a clear
    always_comb begin
        wel_nxt = wel_r;
        vol_nxt = vol_r;
        req_nxt = 1'b0;
        if (sif.done || sif.wr_vol || (abusy_d_r && !array_busy)) begin
            wel_nxt = 1'b0;
        end
        if (exec && opc_r == OP_LATCH_CLR) begin
            wel_nxt = 1'b0;
        end
        if (exec && opc_r == OP_LATCH_SET) begin
            wel_nxt = 1'b1;
        end
        if (exec && opc_r == OP_VOL_EN) begin
            vol_nxt = 1'b1;
        end
        if (exec && opc_r == OP_STAT_WR) begin
            vol_nxt = 1'b0;
        end
        if (exec && is_array_op(opc_r) && wel_r && !busy) begin
            req_nxt = !(is_chip_op(opc_r) && sif.bp != BP_NONE);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_r <= S_IDLE;
            opc_r <= 8'h00;
            sh_r <= 8'h00;
            osh_r <= 8'h00;
            cnt_r <= 5'h00;
            ocnt_r <= 3'h0;
            addr_r <= 24'h000000;
            bad_r <= 1'b0;
            dual_r <= 1'b0;
            l1_r <= 1'b0;
            l0_r <= 1'b0;
            wel_r <= 1'b0;
            vol_r <= 1'b0;
            req_r <= 1'b0;
        end else if (ce) begin
            state_r <= state_nxt;
            opc_r <= opc_nxt;
            sh_r <= sh_nxt;
            osh_r <= osh_nxt;
            cnt_r <= cnt_nxt;
            ocnt_r <= ocnt_nxt;
            addr_r <= addr_nxt;
            bad_r <= bad_nxt;
            dual_r <= dual_nxt;
            l1_r <= l1_nxt;
            l0_r <= l0_nxt;
            wel_r <= wel_nxt;
            vol_r <= vol_nxt;
            req_r <= req_nxt;
        end
    end

    // Pins released outside data-out, including after a bad opcode
    assign dual_lane_one_out = l1_r;
    assign dual_lane_zero_out = l0_r;
    assign dual_lane_one_oe = (state_r == S_DOUT);
    assign dual_lane_zero_oe = (state_r == S_DOUT) && dual_r;
    assign array_req = req_r;
    assign array_op = opc_r;
    assign array_addr = addr_r;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    chk_latch_set_cmd: assert property (exec && opc_r == OP_LATCH_SET |=> wel_r)
        else $error("latch set command did not set latch");
    chk_latch_clr_cmd: assert property (exec && opc_r == OP_LATCH_CLR |=> !wel_r)
        else $error("latch clear command did not clear latch");
    chk_vol_keeps_latch: assert property (exec && opc_r == OP_VOL_EN && !sif.done &&
        !array_busy && !abusy_d_r |=> wel_r == $past(wel_r))
        else $error("volatile enable changed the latch");
    chk_status_layout: assert property (state_r == S_DOUT && opc_r == OP_STAT_RD &&
        sclk_fall && ocnt_r == 3'h0 |=> dual_lane_one_out == $past(sif.lock))
        else $error("status byte top bit is not the lock bit");
    chk_no_write_unlatched: assert property (exec && !wel_r |-> !sif.wr_nv && !sif.wr_vol
        ##1 !array_req)
        else $error("write accepted with latch clear");
    chk_hw_protect: assert property (exec && opc_r == OP_STAT_WR && hw_lock
        |-> !sif.wr_nv && !sif.wr_vol)
        else $error("status write accepted in hardware-protected mode");
    chk_chip_protected: assert property (exec && is_chip_op(opc_r) && sif.bp != BP_NONE
        |=> !array_req)
        else $error("chip erase issued with protection set");
    chk_busy_in_cycle: assert property (ce && sif.wr_nv && !sif.busy
        |=> status_byte[ST_BUSY] [*4])
        else $error("busy flag dropped during timed write");
    chk_latch_clr_done: assert property (sif.done && ce && !exec |=> !wel_r)
        else $error("latch not cleared at end of timed write");
    chk_ignore_released: assert property (state_r == S_IGNORE |-> !dual_lane_one_oe &&
        !dual_lane_zero_oe)
        else $error("output driven after unknown opcode");
    chk_dual_addr_order: assert property (ce && state_r == S_ADDR && dual_r && sclk_rise &&
        !cs_rise && !cs_fall |=> addr_r[1:0] == $past({d1, d0}))
        else $error("dual address bits in wrong lanes");
    chk_dual_out_order: assert property (ce && state_r == S_DOUT && dual_r && sclk_fall &&
        ocnt_r == 3'h0 |=> dual_lane_one_out == $past(array_rdata[7]) &&
        dual_lane_zero_out == $past(array_rdata[6]))
        else $error("dual output bit pair misplaced");

    cov_latch_set: cover property (exec && opc_r == OP_LATCH_SET);
    cov_timed_write: cover property (sif.wr_nv ##[1:1000] sif.done);
    cov_volatile_write: cover property (sif.wr_vol);
    cov_dual_read: cover property (state_r == S_DUMMY ##1 state_r == S_DOUT);
endmodule : sfsw_top

// ### inc/sfsw_pkg.sv
package sfsw_pkg;
    // Opcodes
    localparam logic [7:0] OP_LATCH_SET = 8'h06;
    localparam logic [7:0] OP_LATCH_CLR = 8'h04;
    localparam logic [7:0] OP_VOL_EN = 8'h50;
    localparam logic [7:0] OP_STAT_RD = 8'h05;
    localparam logic [7:0] OP_CFG_RD = 8'h15;
    localparam logic [7:0] OP_STAT_WR = 8'h01;
    localparam logic [7:0] OP_CFG_WR = 8'h11;
    localparam logic [7:0] OP_DUAL_RD = 8'hBB;
    localparam logic [7:0] OP_PAGE_PROG = 8'h02;
    localparam logic [7:0] OP_PAGE_WIPE = 8'h81;
    localparam logic [7:0] OP_4K_WIPE = 8'h20;
    localparam logic [7:0] OP_HALF_WIPE = 8'h52;
    localparam logic [7:0] OP_BLK_WIPE = 8'hD8;
    localparam logic [7:0] OP_CHIP_WIPE_A = 8'h60;
    localparam logic [7:0] OP_CHIP_WIPE_B = 8'hC7;
    // Status and configuration byte layout
    localparam int ST_BUSY = 0;
    localparam int ST_LATCH = 1;
    localparam int ST_BP_LO = 2;
    localparam int ST_BP_HI = 6;
    localparam int ST_LOCK = 7;
    localparam int CFG_DUMMY = 7;
    localparam int BP_W = 5;
    localparam logic [BP_W-1:0] BP_NONE = 5'h00;
    localparam logic [BP_W-1:0] BP_RESET = 5'h00;
    localparam logic LOCK_RESET = 1'b0;
    localparam logic DUMMY_RESET = 1'b0;
    localparam logic [6:0] CFG_RSVD = 7'h00;
    // Serial phase lengths in serial clocks, then the last output count of a byte
    localparam logic [4:0] BYTE_CLK = 5'h08;
    localparam logic [4:0] ADDR_CLK_SINGLE = 5'h18;
    localparam logic [4:0] ADDR_CLK_DUAL = 5'h0C;
    localparam logic [4:0] DUMMY_SHORT = 5'h04;
    localparam logic [4:0] DUMMY_LONG = 5'h08;
    localparam logic [2:0] OUT_LAST_SINGLE = 3'h7;
    localparam logic [2:0] OUT_LAST_DUAL = 3'h3;
    // Pin synchroniser lanes
    localparam int SY_SCLK = 0;
    localparam int SY_CS = 1;
    localparam int SY_L0 = 2;
    localparam int SY_L1 = 3;
    localparam int SY_LOCK = 4;
    localparam int SY_W = 5;
    localparam logic [SY_W-1:0] SY_RESET = 5'h12;
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    typedef enum logic [7:0] {
        S_IDLE = 8'h01,
        S_CMD = 8'h02,
        S_ADDR = 8'h04,
        S_DUMMY = 8'h08,
        S_DOUT = 8'h10,
        S_DIN = 8'h20,
        S_HOLD = 8'h40,
        S_IGNORE = 8'h80
    } sfsw_state_t;
endpackage : sfsw_pkg

// ### inc/sfsw_store_if.sv
`timescale 1ns/1ps
interface sfsw_store_if;
    import sfsw_pkg::*;
    logic wr_nv;
    logic wr_vol;
    logic wr_cfg;
    logic [7:0] wr_data;
    logic busy;
    logic done;
    logic [BP_W-1:0] bp;
    logic lock;
    logic dum;
    modport ctl (output wr_nv, wr_vol, wr_cfg, wr_data, input busy, done, bp, lock, dum);
    modport store (input wr_nv, wr_vol, wr_cfg, wr_data, output busy, done, bp, lock, dum);
endinterface : sfsw_store_if

// ### src/sfsw_reg_store.sv
`timescale 1ns/1ps
module sfsw_reg_store
    import sfsw_pkg::*;
#(
    parameter int WRITE_CYCLES = 100000
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic ce,
    sfsw_store_if.store sif
);
    localparam int CW = $clog2(WRITE_CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(WRITE_CYCLES);
    localparam logic [CW-1:0] ONE = CW'(1);
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic [BP_W-1:0] bp_r, bp_nxt;
    logic lock_r, lock_nxt;
    logic dum_r, dum_nxt;
    logic done_r, done_nxt;
    logic cfg_r, cfg_nxt;
    logic [7:0] data_r, data_nxt;

    // Self-timed cycle; new bits apply only when it ends
    always_comb begin
        cnt_nxt = cnt_r;
        bp_nxt = bp_r;
        lock_nxt = lock_r;
        dum_nxt = dum_r;
        cfg_nxt = cfg_r;
        data_nxt = data_r;
        done_nxt = 1'b0;
        if (cnt_r != '0) begin
            cnt_nxt = cnt_r - ONE;
            if (cnt_r == ONE) begin
                done_nxt = 1'b1;
                if (cfg_r) begin
                    dum_nxt = data_r[CFG_DUMMY];
                end else begin
                    bp_nxt = data_r[ST_BP_HI:ST_BP_LO];
                    lock_nxt = data_r[ST_LOCK];
                end
            end
        end else if (sif.wr_nv) begin
            cnt_nxt = LOAD;
            cfg_nxt = sif.wr_cfg;
            data_nxt = sif.wr_data;
        end else if (sif.wr_vol) begin
            // Volatile copy changes at once, no timed cycle
            bp_nxt = sif.wr_data[ST_BP_HI:ST_BP_LO];
            lock_nxt = sif.wr_data[ST_LOCK];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cnt_r <= '0;
            bp_r <= BP_RESET;
            lock_r <= LOCK_RESET;
            dum_r <= DUMMY_RESET;
            cfg_r <= 1'b0;
            data_r <= 8'h00;
            done_r <= 1'b0;
        end else if (ce) begin
            cnt_r <= cnt_nxt;
            bp_r <= bp_nxt;
            lock_r <= lock_nxt;
            dum_r <= dum_nxt;
            cfg_r <= cfg_nxt;
            data_r <= data_nxt;
            done_r <= done_nxt;
        end
    end

    assign sif.busy = (cnt_r != '0);
    assign sif.done = done_r;
    assign sif.bp = bp_r;
    assign sif.lock = lock_r;
    assign sif.dum = dum_r;

    chk_write_starts_busy: assert property (@(posedge ref_clk) disable iff (reset)
        ce && sif.wr_nv && !sif.busy |=> sif.busy)
        else $error("timed write did not start");
endmodule : sfsw_reg_store

// ### verif/sfsw_host.sv
`timescale 1ns/1ps
module sfsw_host (
    input wire logic ref_clk,
    input wire logic miso,
    input wire logic miso0,
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    output logic lane1
);
    int half;
    // Mode 0 host, clock idles low between frames
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
        lane1 = 1'b1;
        half = 6;
    end
    // Halves of 6 and 7 cycles give a 130 ns serial period
    // Lane zero carries d[0], lane one d[1]; both output lanes are sampled
    task automatic bit_clk(input logic [1:0] d, output logic [1:0] q);
        mosi <= d[0];
        lane1 <= d[1];
        repeat (half) @(posedge ref_clk);
        q = {miso, miso0};
        sclk <= 1'b1;
        half = 13 - half;
        repeat (half) @(posedge ref_clk);
        sclk <= 1'b0;
    endtask : bit_clk
    // One frame: opcode, then nd data bits in or out
    task automatic frame(input logic [7:0] op, input logic [7:0] dat, input int nd,
                         output logic [7:0] rd);
        logic [1:0] q;
        cs_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        for (int i = 7; i >= 0; i--) bit_clk({~lane1, op[i]}, q);
        for (int i = 7; i > 7 - nd; i--) begin
            bit_clk({~lane1, dat[i]}, q);
            rd[i] = q[1];
        end
        repeat (3) @(posedge ref_clk);
        cs_n <= 1'b1;
        mosi <= ~mosi; // Released line never shows the last bit
        repeat (12) @(posedge ref_clk);
    endtask : frame
    // Dual read: single-lane opcode, 12 address pairs, dummies, one byte in pairs
    task automatic dual_rd(input logic [7:0] op, input logic [23:0] a, input int ndum,
                           output logic [7:0] rd);
        logic [1:0] q;
        cs_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        for (int i = 7; i >= 0; i--) bit_clk({~lane1, op[i]}, q);
        for (int i = 23; i > 0; i -= 2) bit_clk(a[i -: 2], q);
        repeat (ndum) bit_clk({~lane1, ~mosi}, q);
        for (int i = 7; i > 0; i -= 2) begin
            bit_clk({~lane1, ~mosi}, q);
            rd[i -: 2] = q;
        end
        repeat (3) @(posedge ref_clk);
        cs_n <= 1'b1;
        mosi <= ~mosi;
        repeat (12) @(posedge ref_clk);
    endtask : dual_rd
endmodule : sfsw_host

// ### verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import sfsw_pkg::*;
    logic ref_clk, reset, sclk, cs_n, l0_in, l1_in, lock_pin_n, l0_out, l0_oe, l1_out, l1_oe;
    logic array_req, array_busy;
    logic [7:0] array_op, rd;
    logic [23:0] array_addr;
    int bad_count, n_compared, cycles, req_seen, oe_seen, mark;
    sfsw_top #(.WRITE_TIME_NS(5000)) dut_u (.ref_clk(ref_clk), .reset(reset), .ce(1'b1),
        .sclk(sclk), .cs_n(cs_n), .dual_lane_zero_in(l0_in), .dual_lane_one_in(l1_in),
        .lock_pin_n(lock_pin_n), .dual_lane_zero_out(l0_out), .dual_lane_zero_oe(l0_oe),
        .dual_lane_one_out(l1_out), .dual_lane_one_oe(l1_oe), .array_busy(array_busy),
        .array_rdata(8'hA5), .array_req(array_req), .array_op(array_op),
        .array_addr(array_addr));
    // Released lanes show the inverse, so a late output enable cannot pass
    sfsw_host host_u (.ref_clk(ref_clk), .miso(l1_oe ? l1_out : ~l1_out),
        .miso0(l0_oe ? l0_out : ~l0_out), .sclk(sclk), .cs_n(cs_n),
        .mosi(l0_in), .lane1(l1_in));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Watchdog and pulse counters
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (array_req === 1'b1) req_seen <= req_seen + 1;
        if (l1_oe === 1'b1 || l0_oe === 1'b1) oe_seen <= oe_seen + 1;
        if (cycles == 60000) begin
            bad_count = bad_count + 1;
            final_report();
        end
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic cmd(input logic [7:0] op);
        host_u.frame(op, 8'h00, 0, rd);
    endtask : cmd
    task automatic rd_chk(input logic [7:0] op, input logic [7:0] exp);
        host_u.frame(op, 8'h00, 8, rd);
        check("register", rd, exp);
    endtask : rd_chk
    // Latch set first, as every write must be
    task automatic wr(input logic [7:0] op, input logic [7:0] dat);
        cmd(OP_LATCH_SET);
        host_u.frame(op, dat, 8, rd);
        repeat (600) @(posedge ref_clk);
    endtask : wr
    task automatic t_latch();
        rd_chk(OP_STAT_RD, 8'h00);
        cmd(OP_LATCH_SET);
        rd_chk(OP_STAT_RD, 8'h02);
        cmd(OP_LATCH_CLR);
        rd_chk(OP_STAT_RD, 8'h00);
        host_u.frame(OP_STAT_WR, 8'h1C, 8, rd);
        rd_chk(OP_STAT_RD, 8'h00);
        cmd(OP_VOL_EN);
        rd_chk(OP_STAT_RD, 8'h00);
        cmd(OP_LATCH_SET);
        host_u.frame(OP_STAT_WR, 8'h1C, 8, rd);
        rd_chk(OP_STAT_RD, 8'h1C);
    endtask : t_latch
    task automatic t_dual(input int ndum);
        host_u.dual_rd(OP_DUAL_RD, 24'h5A3C00, ndum, rd);
        check("dual_data", rd, 8'hA5);
        check("dual_addr_hi", array_addr[23:16], 8'h5A);
        check("dual_addr_mid", array_addr[15:8], 8'h3C);
    endtask : t_dual
    task automatic t_status();
        cmd(OP_LATCH_SET);
        host_u.frame(OP_STAT_WR, 8'h9C, 8, rd);
        rd_chk(OP_STAT_RD, 8'h1F);
        repeat (600) @(posedge ref_clk);
        rd_chk(OP_STAT_RD, 8'h9C);
        lock_pin_n <= 1'b0;
        wr(OP_STAT_WR, 8'h00);
        rd_chk(OP_STAT_RD, 8'h9E);
        lock_pin_n <= 1'b1;
        wr(OP_STAT_WR, 8'h00);
        rd_chk(OP_STAT_RD, 8'h00);
        cmd(OP_LATCH_SET);
        host_u.frame(OP_STAT_WR, 8'h9C, 7, rd);
        rd_chk(OP_STAT_RD, 8'h02);
    endtask : t_status
    task automatic t_config();
        wr(OP_CFG_WR, 8'h80);
        rd_chk(OP_CFG_RD, 8'h80);
        rd_chk(OP_STAT_RD, 8'h00);
    endtask : t_config
    task automatic t_erase();
        mark = req_seen;
        cmd(OP_LATCH_SET);
        cmd(OP_CHIP_WIPE_B);
        check("erase_req", 8'(req_seen - mark), 8'h01);
        check("erase_op", array_op, OP_CHIP_WIPE_B);
        array_busy <= 1'b1;
        rd_chk(OP_STAT_RD, 8'h03);
        array_busy <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rd_chk(OP_STAT_RD, 8'h00);
        wr(OP_STAT_WR, 8'h04);
        mark = req_seen;
        cmd(OP_LATCH_SET);
        cmd(OP_CHIP_WIPE_B);
        check("erase_req", 8'(req_seen - mark), 8'h00);
    endtask : t_erase
    task automatic t_unknown();
        mark = oe_seen;
        host_u.frame(8'hFF, 8'h00, 8, rd);
        check("oe_cycles", 8'(oe_seen - mark), 8'h00);
    endtask : t_unknown
    task automatic final_report();
        if (bad_count == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report
    // Main sequence
    initial begin
        reset = 1'b1;
        lock_pin_n = 1'b1;
        array_busy = 1'b0;
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (5) @(posedge ref_clk);
        t_latch();
        t_dual(int'(DUMMY_SHORT));
        t_status();
        t_config();
        t_dual(int'(DUMMY_LONG));
        t_erase();
        t_unknown();
        final_report();
    end
endmodule : tb_top
